/* dv/dcim_operator.sv */
// Model of the operator contact switches and keypad keys, with contact bounce.
`timescale 1ns/1ps
module dcim_operator
    import dcim_pkg::*;
#(
    parameter int unsigned DB_P = 4
) (
    input wire logic clk_i,
    output dcim_contacts_t contacts_o
);
    // The stop contact idles closed, so the three wire mode is not held stopped.
    logic [CONTACT_W-1:0] lvl = 8'h80;
    assign contacts_o = dcim_contacts_t'(lvl);

    // ----------------------------------------------------------------
    // Contact actions
    // ----------------------------------------------------------------
    // Each change bounces once before it settles, then waits out the filter.
    // maintained run levels
    task automatic set(input int i, input logic v);
        @(posedge clk_i);
        lvl[i] <= v;
        @(posedge clk_i);
        lvl[i] <= ~v;
        @(posedge clk_i);
        lvl[i] <= v;
        repeat (DB_P + 10) @(posedge clk_i);
    endtask

    task automatic press(input int i);
        set(i, 1'b1);
        set(i, 1'b0);
    endtask

    // A pulse shorter than the filter, as from a knock on the switch.
    task automatic glitch(input int i);
        @(posedge clk_i);
        lvl[i] <= ~lvl[i];
        repeat (2) @(posedge clk_i);
        lvl[i] <= ~lvl[i];
        repeat (DB_P + 10) @(posedge clk_i);
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking testbench for the control input mode logic.
`timescale 1ns/1ps
module testbench;
    import dcim_pkg::*;
    localparam int SH = 4;
    localparam int FWD = 5;
    localparam int REV = 6;
    localparam int PK = 3;
    localparam int DIR = 2;
    localparam int KS = 1;
    localparam int KX = 0;
    localparam int STP = 7;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic motor_stopped_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ce_i = 1'b1;
    dcim_contacts_t contacts;
    logic [31:0] rdata_o, d;
    logic run_cmd_o, dir_rev_o, alt_ramp_o, drive_enable_o, local_terminal_o;
    logic fault_clear_o, program_mode_o, led_fwd_o, led_rev_o;
    int mismatches = 0;
    int num_checks = 0;
    int fc_cnt = 0;
    int exp_fc = 0;
    int n;

    always #50 clk_i = ~clk_i;

    dcim_operator #(.DB_P(4)) dcim_operator_i (.clk_i(clk_i), .contacts_o(contacts));

    dcim_top #(.DEBOUNCE_CYC_P(4), .BLINK_CYC_P(8)) dcim_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .contacts_i(contacts),
        .motor_stopped_i(motor_stopped_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .run_cmd_o(run_cmd_o),
        .dir_rev_o(dir_rev_o), .alt_ramp_o(alt_ramp_o), .drive_enable_o(drive_enable_o),
        .local_terminal_o(local_terminal_o), .fault_clear_o(fault_clear_o),
        .program_mode_o(program_mode_o), .led_fwd_o(led_fwd_o), .led_rev_o(led_rev_o));

    // Counting pulses catches both a missing and a stretched fault clear.
    always @(posedge clk_i) begin
        if (fault_clear_o === 1'b1) begin
            fc_cnt++;
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The tests need about 700 cycles; the 5000 cycle limit, some seven times that, means a hang.
    initial begin
        #500_000;
        mismatches++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(ADDR_CTRL, d);
        check(d, 32'h0000_0000, "mode after reset");
        check(program_mode_o, 1'h0, "display mode after reset");
        dcim_operator_i.press(PK);
        check(program_mode_o, 1'h1, "program mode entry");
        dcim_operator_i.press(PK);
        check(program_mode_o, 1'h0, "program mode abort");
        // A key press while the clock enable is low must leave no trace.
        ce_i <= 1'b0;
        dcim_operator_i.press(PK);
        ce_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(program_mode_o, 1'h0, "entry key ignored while frozen");
        $display("test reset_keypad done");

        for (int m = 4; m <= 6; m++) begin
            wr(ADDR_CTRL, 32'(m));
            rd(ADDR_CTRL, d);
            check(d, 32'(m), "mode readback");
            for (int s = 1; s >= 0; s--) begin
                dcim_operator_i.set(SH, s[0]);
                exp_fc++;
                check({alt_ramp_o, drive_enable_o, local_terminal_o},
                      {m == 4 && s == 0, !(m == 5 && s == 0), m == 6 && s == 0},
                      "shared select outputs");
                check(fc_cnt, exp_fc, "fault clear count");
            end
        end
        wr(ADDR_CTRL, 32'h0000_0007);
        rd(ADDR_CTRL, d);
        check(d, 32'h0000_0006, "out of range mode refused");
        rd(4'h8, d);
        check(d, 32'h0000_0000, "unmapped read");
        wr(ADDR_CTRL, 32'h0000_0001);
        dcim_operator_i.set(SH, 1'b1);
        dcim_operator_i.set(SH, 1'b0);
        check(fc_cnt, exp_fc, "no fault clear outside modes 4 to 6");
        $display("test mode_table done");

        wr(ADDR_CTRL, 32'h0000_0005);
        dcim_operator_i.set(SH, 1'b1);
        dcim_operator_i.set(FWD, 1'b1);
        check({run_cmd_o, dir_rev_o}, 2'h2, "forward run");
        dcim_operator_i.set(SH, 1'b0);
        check({run_cmd_o, drive_enable_o}, 2'h0, "disable stops drive");
        dcim_operator_i.set(SH, 1'b1);
        check(run_cmd_o, 1'h0, "no restart without toggle");
        dcim_operator_i.set(FWD, 1'b0);
        dcim_operator_i.set(REV, 1'b1);
        check({run_cmd_o, dir_rev_o}, 2'h3, "reverse run after toggle");
        dcim_operator_i.set(REV, 1'b0);
        check(run_cmd_o, 1'h0, "released run input stops");
        dcim_operator_i.set(SH, 1'b0);
        exp_fc += 4;
        check(fc_cnt, exp_fc, "fault clear count mode 5");
        $display("test restart done");

        wr(ADDR_CTRL, 32'h0000_0004);
        dcim_operator_i.glitch(SH);
        check(fc_cnt, exp_fc, "bounce gives no fault clear");
        check(alt_ramp_o, 1'h1, "bounce leaves ramps");
        rd(ADDR_STATUS, d);
        check(d, 32'h0000_9380, "status after bounce");
        $display("test bounce done");

        wr(ADDR_CTRL, 32'h0000_0003);
        dcim_operator_i.press(FWD);
        check({run_cmd_o, dir_rev_o}, 2'h2, "momentary forward start");
        wr(ADDR_CTRL, 32'h0000_0000);
        dcim_operator_i.press(FWD);
        check(run_cmd_o, 1'h1, "three wire start");
        dcim_operator_i.set(STP, 1'b0);
        check(run_cmd_o, 1'h0, "open stop contact stops");
        dcim_operator_i.set(STP, 1'b1);
        check(run_cmd_o, 1'h0, "no restart when stop closes");
        $display("test terminal_modes done");

        wr(ADDR_CTRL, 32'h0000_0002);
        dcim_operator_i.press(KS);
        check({run_cmd_o, led_fwd_o, led_rev_o}, 3'h6, "keypad forward run");
        dcim_operator_i.press(DIR);
        check({dir_rev_o, led_rev_o}, 2'h3, "new direction lit");
        n = 0;
        #1;
        d[0] = led_fwd_o;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (led_fwd_o !== d[0]) begin
                n++;
            end
            d[0] = led_fwd_o;
        end
        check(n >= 2, 1'h1, "old indicator flashes");
        @(posedge clk_i);
        motor_stopped_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        check({led_fwd_o, led_rev_o}, 2'h1, "flash ends at zero speed");
        dcim_operator_i.press(KX);
        check(run_cmd_o, 1'h0, "keypad stop key stops");
        $display("test direction done");
        stop_test();
    end
endmodule

/* hw/dcim_debounce.sv */
// Synchroniser and debounce filter, one lane per contact input.
`timescale 1ns/1ps
module dcim_debounce
    import dcim_pkg::*;
#(
    parameter int unsigned N = CONTACT_W,
    parameter int unsigned CYC = DEBOUNCE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [N-1:0] raw_i,
    output logic [N-1:0] clean_o
);
    localparam int unsigned CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYC);

    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] stable;
        logic [N-1:0][CW-1:0] cnt;
    } dcim_db_state_t;

    dcim_db_state_t s;
    dcim_db_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.sync1 = raw_i;
        next_s.sync2 = s.sync1;
        for (int i = 0; i < N; i++) begin
            if (s.sync2[i] == s.stable[i]) begin
                next_s.cnt[i] = '0;
            end else if (s.cnt[i] == LIMIT) begin
                next_s.stable[i] = s.sync2[i];
                next_s.cnt[i] = '0;
            end else begin
                next_s.cnt[i] = s.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign clean_o = s.stable;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic any_full;
    always_comb begin
        any_full = 1'b0;
        for (int i = 0; i < N; i++) begin
            any_full = any_full | (s.cnt[i] == LIMIT);
        end
    end

    a_bounce_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        !$stable(s.stable) |-> $past(any_full) && $past(ce_i))
        else $error("debounced input changed before the filter time ran out");
endmodule

/* hw/dcim_top.sv */
// Control input mode logic: run qualification, shared input, keypad and indicators.
`timescale 1ns/1ps
module dcim_top
    import dcim_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC_P = DEBOUNCE_CYC,
    parameter int unsigned BLINK_CYC_P = BLINK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire dcim_contacts_t contacts_i,
    input wire logic motor_stopped_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic run_cmd_o,
    output logic dir_rev_o,
    output logic alt_ramp_o,
    output logic drive_enable_o,
    output logic local_terminal_o,
    output logic fault_clear_o,
    output logic program_mode_o,
    output logic led_fwd_o,
    output logic led_rev_o
);
    localparam int unsigned BW = $clog2(BLINK_CYC_P + 1);
    localparam logic [BW-1:0] BLINK_LIMIT = BW'(BLINK_CYC_P);

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        dcim_kp_state_t kp;
        dcim_contacts_t prev;
        logic run;
        logic dir_rev;
        logic armed;
        logic flash;
        logic [BW-1:0] blink_cnt;
        logic blink;
        logic alt_ramp;
        logic enable;
        logic local_ctl;
        logic fault_clr;
        logic led_fwd;
        logic led_rev;
        logic [31:0] rdata;
    } dcim_state_t;

    dcim_state_t s;
    dcim_state_t next_s;
    dcim_contacts_t db;
    dcim_contacts_t rise;
    logic [CONTACT_W-1:0] db_vec;
    logic maint;
    logic stop_ok;
    logic enabled;
    logic run_req;
    logic [31:0] status;

    dcim_debounce #(
        .N(CONTACT_W),
        .CYC(DEBOUNCE_CYC_P)
    ) u_debounce (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .raw_i(CONTACT_W'(contacts_i)),
        .clean_o(db_vec)
    );

    assign db = dcim_contacts_t'(db_vec);
    assign rise = dcim_contacts_t'(db_vec & ~CONTACT_W'(s.prev));

    always_comb begin
        status = '0;
        status[ST_CONTACT_LSB +: CONTACT_W] = db_vec;
        status[ST_ALT_RAMP] = s.alt_ramp;
        status[ST_ENABLE] = s.enable;
        status[ST_LOCAL] = s.local_ctl;
        status[ST_RUN] = s.run;
        status[ST_DIR_REV] = s.dir_rev;
        status[ST_FLASH] = s.flash;
        status[ST_PROGRAM] = (s.kp == DCIM_KP_PROGRAM);
        status[ST_ARMED] = s.armed;
    end

    always_comb begin
        next_s = s;
        next_s.prev = db;
        maint = (s.mode >= MODE_ACCEL_DECEL);
        run_req = db.run_fwd | db.run_rev;
        // The three terminal modes below 4 use terminal 8 as a stop contact.
        stop_ok = maint || (s.mode == MODE_KEYPAD) || db.stop;
        enabled = (s.mode != MODE_ENABLE) || db.shared_sel;
        next_s.enable = enabled;
        next_s.alt_ramp = (s.mode == MODE_ACCEL_DECEL) && !db.shared_sel;
        next_s.local_ctl = (s.mode == MODE_LOCAL_REMOTE) && !db.shared_sel;
        next_s.fault_clr = maint && (db.shared_sel != s.prev.shared_sel);

        if (!run_req) begin
            next_s.armed = 1'b1;
        end
        unique case (s.mode)
            MODE_THREE_WIRE: begin
                if (rise.run_fwd) begin
                    next_s.run = 1'b1;
                end
                next_s.dir_rev = db.run_rev;
            end
            MODE_KEYPAD: begin
                if (rise.kp_start) begin
                    next_s.run = 1'b1;
                end
                if (rise.dir_key) begin
                    next_s.dir_rev = !s.dir_rev;
                end
            end
            MODE_MOMENTARY: begin
                if (rise.run_fwd) begin
                    next_s.run = 1'b1;
                    next_s.dir_rev = 1'b0;
                end else if (rise.run_rev) begin
                    next_s.run = 1'b1;
                    next_s.dir_rev = 1'b1;
                end
            end
            default: begin
                // Maintained two-wire modes: run only while armed and held.
                next_s.run = s.armed && run_req;
                if (run_req) begin
                    next_s.dir_rev = db.run_rev;
                end
                if (s.run && !run_req) begin
                    next_s.armed = 1'b1;
                end
            end
        endcase
        if (!stop_ok || !enabled || rise.kp_stop) begin
            next_s.run = 1'b0;
            next_s.armed = 1'b0;
        end

        if (s.run && (next_s.dir_rev != s.dir_rev)) begin
            next_s.flash = 1'b1;
        end else if (motor_stopped_i) begin
            next_s.flash = 1'b0;
        end
        if (!s.flash || s.blink_cnt == BLINK_LIMIT) begin
            next_s.blink_cnt = '0;
            next_s.blink = s.flash && !s.blink;
        end else begin
            next_s.blink_cnt = s.blink_cnt + BW'(1);
        end
        next_s.led_fwd = !s.dir_rev || (s.flash && s.blink);
        next_s.led_rev = s.dir_rev || (s.flash && s.blink);

        unique case (s.kp)
            DCIM_KP_DISPLAY: begin
                if (rise.program_entry_key) begin
                    next_s.kp = DCIM_KP_PROGRAM;
                end
            end
            DCIM_KP_PROGRAM: begin
                // A second press aborts editing and returns to display.
                if (rise.program_entry_key) begin
                    next_s.kp = DCIM_KP_DISPLAY;
                end
            end
        endcase

        if (wr_i && addr_i == ADDR_CTRL) begin
            if (wdata_i[CTRL_MODE_LSB +: MODE_W] <= MODE_MAX) begin
                next_s.mode = wdata_i[CTRL_MODE_LSB +: MODE_W];
                // A new method never inherits a run latched under the old one.
                if (wdata_i[CTRL_MODE_LSB +: MODE_W] != s.mode) begin
                    next_s.run = 1'b0;
                    next_s.armed = 1'b0;
                end
            end
        end
        next_s.rdata = '0;
        if (rd_i) begin
            if (addr_i == ADDR_CTRL) begin
                next_s.rdata[CTRL_MODE_LSB +: MODE_W] = s.mode;
            end else if (addr_i == ADDR_STATUS) begin
                next_s.rdata = status;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign run_cmd_o = s.run;
    assign dir_rev_o = s.dir_rev;
    assign alt_ramp_o = s.alt_ramp;
    assign drive_enable_o = s.enable;
    assign local_terminal_o = s.local_ctl;
    assign fault_clear_o = s.fault_clr;
    assign program_mode_o = (s.kp == DCIM_KP_PROGRAM);
    assign led_fwd_o = s.led_fwd;
    assign led_rev_o = s.led_rev;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_mode_in_range: assert property (s.mode <= MODE_MAX)
        else $error("input mode left the legal range");
    a_alt_ramp_open: assert property (ce_i && s.mode == MODE_ACCEL_DECEL
        |=> alt_ramp_o == !$past(db.shared_sel))
        else $error("ramp select does not follow the shared input");
    a_enable_coast: assert property (ce_i && s.mode == MODE_ENABLE && !db.shared_sel
        |=> !drive_enable_o && !run_cmd_o)
        else $error("drive not disabled while enable contact is open");
    a_local_force: assert property (ce_i && s.mode == MODE_LOCAL_REMOTE
        |=> local_terminal_o == !$past(db.shared_sel))
        else $error("local or remote selection is wrong");
    a_restart_toggle: assert property (ce_i && maint && !s.armed && !s.run
        && !(wr_i && addr_i == ADDR_CTRL) |=> !run_cmd_o)
        else $error("run restarted without a toggle of the run input");
    a_fault_clear: assert property (fault_clear_o
        |-> $past(maint) && $past(db.shared_sel) != $past(s.prev.shared_sel))
        else $error("fault clear without a shared input change");
    a_display_power: assert property ($rose(program_mode_o)
        |-> $past(rise.program_entry_key) && $past(ce_i))
        else $error("program mode entered without the entry key");
    a_program_entry: assert property (ce_i && s.kp == DCIM_KP_DISPLAY
        && rise.program_entry_key |=> program_mode_o)
        else $error("entry key did not enter program mode");
    a_dir_flash: assert property (ce_i && s.run && next_s.dir_rev != s.dir_rev
        |=> s.flash ##1 (led_fwd_o && led_rev_o) == s.blink)
        else $error("direction change while running did not flash");

    c_mode4_alt: cover property (s.mode == MODE_ACCEL_DECEL && alt_ramp_o && run_cmd_o);
    c_mode5_drop: cover property (s.mode == MODE_ENABLE && $fell(drive_enable_o));
    c_fault_clr: cover property (fault_clear_o);
    c_flash_seen: cover property (s.flash && s.blink);
endmodule

/* pkg/dcim_pkg.sv */
// Constants, types and carriers shared by the drive control input mode logic.
package dcim_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned DEBOUNCE_TIME_NS = 5_000_000;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLINK_HALF_NS = 250_000_000;
    localparam int unsigned BLINK_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned ST_CONTACT_LSB = 0;
    localparam int unsigned ST_ALT_RAMP = 8;
    localparam int unsigned ST_ENABLE = 9;
    localparam int unsigned ST_LOCAL = 10;
    localparam int unsigned ST_RUN = 11;
    localparam int unsigned ST_DIR_REV = 12;
    localparam int unsigned ST_FLASH = 13;
    localparam int unsigned ST_PROGRAM = 14;
    localparam int unsigned ST_ARMED = 15;

    // ----------------------------------------------------------------
    // Input modes
    // ----------------------------------------------------------------
    localparam int unsigned MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_THREE_WIRE = 3'h0;
    localparam logic [MODE_W-1:0] MODE_TWO_WIRE = 3'h1;
    localparam logic [MODE_W-1:0] MODE_KEYPAD = 3'h2;
    localparam logic [MODE_W-1:0] MODE_MOMENTARY = 3'h3;
    localparam logic [MODE_W-1:0] MODE_ACCEL_DECEL = 3'h4;
    localparam logic [MODE_W-1:0] MODE_ENABLE = 3'h5;
    localparam logic [MODE_W-1:0] MODE_LOCAL_REMOTE = 3'h6;
    localparam logic [MODE_W-1:0] MODE_MAX = 3'h6;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

    typedef enum logic {
        DCIM_KP_DISPLAY = 1'b0,
        DCIM_KP_PROGRAM = 1'b1
    } dcim_kp_state_t;

    // Contact closure inputs, 1 = closed.
    typedef struct packed {
        logic stop;
        logic run_rev;
        logic run_fwd;
        logic shared_sel;
        logic program_entry_key;
        logic dir_key;
        logic kp_start;
        logic kp_stop;
    } dcim_contacts_t;

    localparam int unsigned CONTACT_W = $bits(dcim_contacts_t);

endpackage
